// [design/ocrb_map.vh]
// Purpose: constants for the outbound configuration record bank
// Assumes: byte-wide special-function-register bus, record bytes 0..25
// Notes:   addresses are the bus addresses of each record byte
`ifndef OCRB_MAP_VH
`define OCRB_MAP_VH

`define OCRB_NUM_REGS      26
`define OCRB_REC_BITS      208
`define OCRB_BLOCK_BITS    176
`define OCRB_STATUS_BYTES  16

// record byte addresses
`define OCRB_A_NETID0      8'h88
`define OCRB_A_NETID1      8'h89
`define OCRB_A_UID0        8'h8A
`define OCRB_A_UID1        8'h8B
`define OCRB_A_UID2        8'h8C
`define OCRB_A_UID3        8'h8D
`define OCRB_A_UID4        8'h8E
`define OCRB_A_UID5        8'h91
`define OCRB_A_APP0        8'h92
`define OCRB_A_APP1        8'h93
`define OCRB_A_APP2        8'h94
`define OCRB_A_APP3        8'h95
`define OCRB_A_APP4        8'h96
`define OCRB_A_APP5        8'h97
`define OCRB_A_APP6        8'h98
`define OCRB_A_APP7        8'h99
`define OCRB_A_APP8        8'h9A
`define OCRB_A_APP9        8'h9B
`define OCRB_A_SETUP0      8'h9C
`define OCRB_A_SETUP1      8'h9D
`define OCRB_A_SETUP2      8'h9E
`define OCRB_A_SETUP3      8'hA1
`define OCRB_A_SETUP4      8'hA3
`define OCRB_A_SETUP5      8'hA4
`define OCRB_A_NETID2      8'hA5
`define OCRB_A_NETID3      8'hA6

// record byte indices of each field
`define OCRB_UID_FIRST     2
`define OCRB_UID_LAST      7
`define OCRB_SETUP_FIRST   18

// reset values
`define OCRB_RESET_BYTE    8'h00
`define OCRB_RDATA_UNMAPPED 8'h00

// sensor setup word field positions
`define OCRB_F_DELAY_LSB   2
`define OCRB_F_CONT        4
`define OCRB_F_POWER       5
`define OCRB_F_ENABLE      6
`define OCRB_F_S3RATE_LO   7
`define OCRB_F_S3RATE_HI   8
`define OCRB_F_S2RATE_LSB  9
`define OCRB_F_S1RATE_LSB  11

// sensor switch delay in ms, counted as 1 kHz ticks
`define OCRB_DLY_CODE0_MS  8'h3C
`define OCRB_DLY_CODE1_MS  8'h50
`define OCRB_DLY_CODE2_MS  8'hA0
`define OCRB_DLY_CODE3_MS  8'h78

// modulator filter rates in Hz
`define OCRB_RATE_CODE0_HZ 8'hFA
`define OCRB_RATE_CODE1_HZ 8'h64
`define OCRB_RATE_CODE2_HZ 8'h32
`define OCRB_RATE_CODE3_HZ 8'h19

`endif

// [design/ocrb_byte_reg.v]
// Purpose: one software-writable byte of the record bank
// Assumes: single-cycle write strobe on the system clock
// Notes:   resets to zero
`include "ocrb_map.vh"

module ocrb_byte_reg #(
  parameter [7:0] ADDR = 8'h00
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire       wr_en,
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  output wire [7:0] q
);

  reg [7:0] byte_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byte_reg <= `OCRB_RESET_BYTE;
    end else if (wr_en && (addr == ADDR)) begin
      byte_reg <= wdata;
    end
  end

  assign q = byte_reg;

endmodule

// [design/ocrb_bank.v]
// Purpose: outbound configuration record bank, 26 bytes on the sfr bus
// Assumes: sfr strobes and link control bit come from the system clock
// Notes:   fuse bits are asynchronous to clk and pass two flip-flops

`include "ocrb_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - twenty-six byte registers form one 208-bit record
// - record is sent by base with config-send
// - block is 176 bits in registers 2..23
// - unit identity in registers 2..7, LSB first
// - application payload in registers 8..17, read/write
// - sensor setup word in registers 18..23
// - network identifier in registers 0,1,24,25
// - select 0 on a base: network id in lower identity bits
// - select 1: whole unit identity is sent
// - target reply always carries unit identity
// - target status bytes from outbound or inbound
// - unit identity fuse-fixed, read-only
// - record contents never steer the link controller
// - switch delay code gives 60/80/160/120 ms
// - continuous sampling holds conversion enable high only while setup bit 6 is set
// - setup bit 5 powers sensor front end
// - setup bit 6 enables controller; bits 1:0 reserved
// - setup bit 7 is sensor 3 rate low
// - rate code gives 250/100/50/25 Hz
// - target inbound record holds base's outbound record
module ocrb_bank (
  input  wire         clk,
  input  wire         resetn,
  input  wire [7:0]   sfr_addr,
  input  wire [7:0]   sfr_wdata,
  input  wire         sfr_wr,
  input  wire         sfr_rd,
  output wire [7:0]   sfr_rdata,
  output wire         sfr_hit,
  input  wire         station_is_base,
  input  wire         identity_source_select,
  input  wire [47:0]  fused_unit_identity,
  input  wire [127:0] inbound_record,
  output wire [207:0] config_send_record,
  output wire [127:0] status_data,
  output wire [47:0]  status_identity,
  output wire [7:0]   sensor_switch_delay_ms,
  output wire         continuous_sampling_enable,
  output wire         conversion_enable_hold,
  output wire         sensor_front_power_enable,
  output wire         sensor_ctrl_enable,
  output wire [1:0]   sensor3_rate_select,
  output wire [1:0]   sensor2_rate_select,
  output wire [1:0]   sensor1_rate_select,
  output wire [7:0]   sensor3_rate_hz,
  output wire [7:0]   sensor2_rate_hz,
  output wire [7:0]   sensor1_rate_hz
);

  ////////////////////////////////////////////////////////////////////////////////
  // address map
  // bus addresses are not contiguous: gaps at 0x8F, 0x90, 0x9F, 0xA0 and 0xA2

  function [7:0] rec_addr;
    input integer idx;
    begin
      case (idx)
        0:       rec_addr = `OCRB_A_NETID0;
        1:       rec_addr = `OCRB_A_NETID1;
        2:       rec_addr = `OCRB_A_UID0;
        3:       rec_addr = `OCRB_A_UID1;
        4:       rec_addr = `OCRB_A_UID2;
        5:       rec_addr = `OCRB_A_UID3;
        6:       rec_addr = `OCRB_A_UID4;
        7:       rec_addr = `OCRB_A_UID5;
        8:       rec_addr = `OCRB_A_APP0;
        9:       rec_addr = `OCRB_A_APP1;
        10:      rec_addr = `OCRB_A_APP2;
        11:      rec_addr = `OCRB_A_APP3;
        12:      rec_addr = `OCRB_A_APP4;
        13:      rec_addr = `OCRB_A_APP5;
        14:      rec_addr = `OCRB_A_APP6;
        15:      rec_addr = `OCRB_A_APP7;
        16:      rec_addr = `OCRB_A_APP8;
        17:      rec_addr = `OCRB_A_APP9;
        18:      rec_addr = `OCRB_A_SETUP0;
        19:      rec_addr = `OCRB_A_SETUP1;
        20:      rec_addr = `OCRB_A_SETUP2;
        21:      rec_addr = `OCRB_A_SETUP3;
        22:      rec_addr = `OCRB_A_SETUP4;
        23:      rec_addr = `OCRB_A_SETUP5;
        24:      rec_addr = `OCRB_A_NETID2;
        25:      rec_addr = `OCRB_A_NETID3;
        default: rec_addr = 8'h00;
      endcase
    end
  endfunction

  // rate codes of all three sensors share one table
  function [7:0] rate_hz;
    input [1:0] code;
    begin
      case (code)
        2'h0:    rate_hz = `OCRB_RATE_CODE0_HZ;
        2'h1:    rate_hz = `OCRB_RATE_CODE1_HZ;
        2'h2:    rate_hz = `OCRB_RATE_CODE2_HZ;
        default: rate_hz = `OCRB_RATE_CODE3_HZ;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // fuse identity, static but unrelated to clk
  // a word-wide two-stage sync is enough only because fuses never change in use

  reg  [47:0]  fuse_meta_reg;
  reg  [47:0]  fuse_sync_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fuse_meta_reg <= 48'h0;
      fuse_sync_reg <= 48'h0;
    end else begin
      fuse_meta_reg <= fused_unit_identity;
      fuse_sync_reg <= fuse_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // record storage

  wire [207:0] rec_flat;

  genvar gi;
  generate
    for (gi = 0; gi < `OCRB_NUM_REGS; gi = gi + 1) begin : g_rec
      if ((gi >= `OCRB_UID_FIRST) && (gi <= `OCRB_UID_LAST)) begin : g_uid
        // no write path exists here, so a stray store cannot alter the fuses
        assign rec_flat[gi*8 +: 8] =
          fuse_sync_reg[(gi-`OCRB_UID_FIRST)*8 +: 8];
      end else begin : g_rw
        ocrb_byte_reg #(
          .ADDR   (rec_addr(gi))
        ) u_byte (
          .clk    (clk),
          .resetn (resetn),
          .wr_en  (sfr_wr),
          .addr   (sfr_addr),
          .wdata  (sfr_wdata),
          .q      (rec_flat[gi*8 +: 8])
        );
      end
    end
  endgenerate

  // the network id is split around the block: two bytes below it, two above
  wire [7:0]   netid_b0     = rec_flat[0*8 +: 8];
  wire [7:0]   netid_b1     = rec_flat[1*8 +: 8];
  wire [7:0]   netid_b2     = rec_flat[24*8 +: 8];
  wire [7:0]   netid_b3     = rec_flat[25*8 +: 8];
  wire [31:0]  network_id   = {netid_b3, netid_b2, netid_b1, netid_b0};
  wire [175:0] cfg_block    = rec_flat[16 +: `OCRB_BLOCK_BITS];
  wire [47:0]  unit_id      = cfg_block[0 +: 48];
  wire [79:0]  app_payload  = cfg_block[48 +: 80];
  wire [47:0]  setup_word   = cfg_block[128 +: 48];

  ////////////////////////////////////////////////////////////////////////////////
  // register read port, answer one cycle after the read strobe
  // a read in the same cycle as a write to that byte returns the old value

  reg  [7:0]   rdata_reg;
  reg  [7:0]   rdata_next;
  reg          hit_reg;
  reg          hit_next;
  integer      k;

  always @* begin
    rdata_next = rdata_reg;
    hit_next   = hit_reg;
    if (sfr_rd) begin
      rdata_next = `OCRB_RDATA_UNMAPPED;
      hit_next   = 1'b0;
      for (k = 0; k < `OCRB_NUM_REGS; k = k + 1) begin
        if (sfr_addr == rec_addr(k)) begin
          rdata_next = rec_flat[k*8 +: 8];
          hit_next   = 1'b1;
        end
      end
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= `OCRB_RDATA_UNMAPPED;
      hit_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      hit_reg   <= hit_next;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign sfr_hit   = hit_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // record towards the link controller
  // the bank only offers data; nothing here feeds back into link timing

  reg  [207:0] send_reg;
  reg  [207:0] send_next;
  reg  [47:0]  ident_field;
  wire         ident_use_netid = station_is_base & ~identity_source_select;

  // on a target the select is ignored and the full unit identity goes out
  always @* begin
    if (ident_use_netid) begin
      ident_field = {unit_id[47:32], network_id};
    end else begin
      ident_field = unit_id;
    end
    send_next = {netid_b3, netid_b2,
                 setup_word,
                 app_payload,
                 ident_field,
                 netid_b1, netid_b0};
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      send_reg <= 208'h0;
    end else begin
      send_reg <= send_next;
    end
  end

  assign config_send_record = send_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // target status reply

  reg  [127:0] status_reg;
  reg  [127:0] status_next;
  reg  [47:0]  status_id_reg;

  // the same select bit picks the source of the first sixteen status bytes
  always @* begin
    if (identity_source_select) begin
      // inbound side carries what the base last configured
      status_next = inbound_record;
    end else begin
      status_next = rec_flat[127:0];
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_reg    <= 128'h0;
      status_id_reg <= 48'h0;
    end else begin
      status_reg    <= status_next;
      status_id_reg <= fuse_sync_reg;
    end
  end

  assign status_data     = status_reg;
  assign status_identity = status_id_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // sensor setup decode

  reg  [7:0]   delay_reg;
  reg  [7:0]   delay_next;
  reg          cont_reg;
  reg          hold_reg;
  reg          power_reg;
  reg          enable_reg;
  reg  [1:0]   s3_rate_reg;
  reg  [1:0]   s2_rate_reg;
  reg  [1:0]   s1_rate_reg;
  reg  [7:0]   s3_hz_reg;
  reg  [7:0]   s2_hz_reg;
  reg  [7:0]   s1_hz_reg;
  // setup bits 1:0 are reserved and have no decode
  wire [1:0]   delay_code = setup_word[`OCRB_F_DELAY_LSB +: 2];
  // the sensor 3 rate code straddles record bytes 18 and 19
  wire [1:0]   s3_code    = {setup_word[`OCRB_F_S3RATE_HI],
                             setup_word[`OCRB_F_S3RATE_LO]};
  wire [1:0]   s2_code    = setup_word[`OCRB_F_S2RATE_LSB +: 2];
  wire [1:0]   s1_code    = setup_word[`OCRB_F_S1RATE_LSB +: 2];

  // note the non-monotonic table: code 2 is longer than code 3
  always @* begin
    case (delay_code)
      2'h0:    delay_next = `OCRB_DLY_CODE0_MS;
      2'h1:    delay_next = `OCRB_DLY_CODE1_MS;
      2'h2:    delay_next = `OCRB_DLY_CODE2_MS;
      default: delay_next = `OCRB_DLY_CODE3_MS;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      delay_reg   <= `OCRB_DLY_CODE0_MS;
      cont_reg    <= 1'b0;
      hold_reg    <= 1'b0;
      power_reg   <= 1'b0;
      enable_reg  <= 1'b0;
      s3_rate_reg <= 2'h0;
      s2_rate_reg <= 2'h0;
      s1_rate_reg <= 2'h0;
      s3_hz_reg   <= `OCRB_RATE_CODE0_HZ;
      s2_hz_reg   <= `OCRB_RATE_CODE0_HZ;
      s1_hz_reg   <= `OCRB_RATE_CODE0_HZ;
    end else begin
      delay_reg   <= delay_next;
      cont_reg    <= setup_word[`OCRB_F_CONT];
      // conversion enable is held only while the controller runs
      hold_reg    <= setup_word[`OCRB_F_CONT] & setup_word[`OCRB_F_ENABLE];
      power_reg   <= setup_word[`OCRB_F_POWER];
      enable_reg  <= setup_word[`OCRB_F_ENABLE];
      s3_rate_reg <= s3_code;
      s2_rate_reg <= s2_code;
      s1_rate_reg <= s1_code;
      s3_hz_reg   <= rate_hz(s3_code);
      s2_hz_reg   <= rate_hz(s2_code);
      s1_hz_reg   <= rate_hz(s1_code);
    end
  end

  assign sensor_switch_delay_ms     = delay_reg;
  assign continuous_sampling_enable = cont_reg;
  assign conversion_enable_hold     = hold_reg;
  assign sensor_front_power_enable  = power_reg;
  assign sensor_ctrl_enable         = enable_reg;
  assign sensor3_rate_select        = s3_rate_reg;
  assign sensor2_rate_select        = s2_rate_reg;
  assign sensor1_rate_select        = s1_rate_reg;
  assign sensor3_rate_hz            = s3_hz_reg;
  assign sensor2_rate_hz            = s2_hz_reg;
  assign sensor1_rate_hz            = s1_hz_reg;

endmodule

// [bench/ocrb_bank_asserts.sv]
// Purpose: port-level assertions for the outbound record bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   record bytes 18/19 carry the low sensor setup bits
module ocrb_bank_asserts (
  input logic         clk,
  input logic         resetn,
  input logic [7:0]   sfr_addr,
  input logic         sfr_rd,
  input logic [7:0]   sfr_rdata,
  input logic         sfr_hit,
  input logic         station_is_base,
  input logic         identity_source_select,
  input logic [127:0] inbound_record,
  input logic [207:0] config_send_record,
  input logic [127:0] status_data,
  input logic [47:0]  status_identity,
  input logic [7:0]   sensor_switch_delay_ms,
  input logic         continuous_sampling_enable,
  input logic         conversion_enable_hold,
  input logic         sensor_front_power_enable,
  input logic         sensor_ctrl_enable,
  input logic [1:0]   sensor3_rate_select,
  input logic [1:0]   sensor1_rate_select,
  input logic [7:0]   sensor1_rate_hz
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [15:0] setup;
  assign setup = config_send_record[159:144];
  //////////////////////////////////////////////////////////////////////////////
  a_unmapped_read: assert property (
    sfr_rd && sfr_addr == 8'h90 |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read not refused");
  a_read_holds: assert property (!sfr_rd |=> $stable(sfr_rdata) && $stable(sfr_hit))
    else $error("read data moved without a read");
  a_delay_code: assert property (
    sensor_switch_delay_ms == (setup[3:2] == 2'h0 ? 8'h3C : setup[3:2] == 2'h1 ? 8'h50 :
    setup[3:2] == 2'h2 ? 8'hA0 : 8'h78))
    else $error("switch delay does not match code");
  a_setup_bits: assert property (
    continuous_sampling_enable == setup[4] && sensor_front_power_enable == setup[5] &&
    sensor_ctrl_enable == setup[6])
    else $error("setup flag outputs disagree with record");
  a_hold_needs_en: assert property (
    conversion_enable_hold == (setup[4] && setup[6]))
    else $error("conversion hold wrong");
  a_s3_rate_split: assert property (sensor3_rate_select == setup[8:7])
    else $error("sensor 3 rate code split wrong");
  a_rate_code: assert property (
    sensor1_rate_select == setup[12:11] && sensor1_rate_hz ==
    (setup[12:11] == 2'h0 ? 8'hFA : setup[12:11] == 2'h1 ? 8'h64 :
    setup[12:11] == 2'h2 ? 8'h32 : 8'h19))
    else $error("sensor 1 rate wrong");
  a_netid_sent: assert property (
    $past(station_is_base) && !$past(identity_source_select) |->
    config_send_record[47:16] == {config_send_record[207:192], config_send_record[15:0]} &&
    config_send_record[63:48] == status_identity[47:32])
    else $error("network id not in identity field");
  a_full_id: assert property (
    !($past(station_is_base) && !$past(identity_source_select)) |->
    config_send_record[63:16] == status_identity)
    else $error("full identity not sent");
  a_status_src: assert property (
    $past(identity_source_select) |-> status_data == $past(inbound_record))
    else $error("status bytes not from inbound record");
endmodule

// [bench/ocrb_mac_model.sv]
// Purpose: far-side stand-in for the link controller and the fuse block
// Assumes: capture pulse marks one delivered config-send message
// Notes:   fuse value is arbitrary, chosen so every byte differs
module ocrb_mac_model #(
  parameter logic [47:0] FUSE_ID = 48'h5A3C_9E17_2B64
) (
  input  logic         clk,
  input  logic         capture,
  input  logic [207:0] config_send_record,
  output logic [47:0]  fused_unit_identity,
  output logic [127:0] inbound_record
);
  timeunit 1ns;
  timeprecision 1ps;
  //////////////////////////////////////////////////////////////////////////////
  assign fused_unit_identity = FUSE_ID;
  // starts from a pattern unlike any record so a wrong source shows
  initial inbound_record = {8{16'hC33C}};
  always @(posedge clk) begin
    if (capture) inbound_record <= config_send_record[127:0];
  end
endmodule

// [bench/outbound_config_record_bank_test.sv]
// Purpose: self-checking bench for the outbound record bank
// Assumes: inputs change at the falling edge, outputs read there too
// Notes:   identity bytes are expected to show the model's fuse value
module outbound_config_record_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] FUSE = 48'h5A3C_9E17_2B64; // arbitrary value
  logic clk = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0, base = 1, sel = 0, capture = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, dly_ms, hz3, hz2, hz1, b0, b1;
  logic sfr_hit, cont, hold, pwr, en;
  logic [1:0] rs3, rs2, rs1;
  logic [47:0] fuse, sid;
  logic [127:0] inb, sdata;
  logic [207:0] rec, e;
  logic [7:0] img [26];
  logic [7:0] atab [26] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h91, 8'h92,
    8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9E,
    8'hA1, 8'hA3, 8'hA4, 8'hA5, 8'hA6};
  logic [7:0] stab [4] = '{8'h50, 8'h74, 8'h98, 8'hEC};
  logic [7:0] dtab [4] = '{8'h3C, 8'h50, 8'hA0, 8'h78};
  logic [7:0] htab [4] = '{8'hFA, 8'h64, 8'h32, 8'h19};
  int err_count = 0, check_count = 0;
  initial forever #5 clk = ~clk;
  ocrb_bank i_dut (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .station_is_base(base), .identity_source_select(sel), .fused_unit_identity(fuse),
    .inbound_record(inb), .config_send_record(rec), .status_data(sdata),
    .status_identity(sid), .sensor_switch_delay_ms(dly_ms), .continuous_sampling_enable(cont),
    .conversion_enable_hold(hold), .sensor_front_power_enable(pwr), .sensor_ctrl_enable(en),
    .sensor3_rate_select(rs3), .sensor2_rate_select(rs2), .sensor1_rate_select(rs1),
    .sensor3_rate_hz(hz3), .sensor2_rate_hz(hz2), .sensor1_rate_hz(hz1));
  ocrb_mac_model #(.FUSE_ID(FUSE)) i_mac (.clk(clk), .capture(capture),
    .config_send_record(rec), .fused_unit_identity(fuse), .inbound_record(inb));
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string what, logic [207:0] exp, logic [207:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(negedge clk);
    sfr_wr = 0;
  endtask
  // identity bytes are fuse-fixed, so the image never takes writes there
  task automatic wr(int i, logic [7:0] d);
    bus(atab[i], d);
    if (i < 2 || i > 7) img[i] = d;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp, logic hit);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1;
    @(negedge clk);
    sfr_rd = 0;
    chk("sfr_rdata", exp, sfr_rdata);
    chk("sfr_hit", hit, sfr_hit);
  endtask
  task automatic rd_all;
    for (int i = 0; i < 26; i++)
      rd(atab[i], (i > 1 && i < 8) ? FUSE[8*i-16 +: 8] : img[i],
         1);
  endtask
  function automatic logic [207:0] exp_rec(logic b, logic s);
    logic [207:0] r;
    for (int i = 0; i < 26; i++) r[8*i +: 8] = img[i];
    r[63:16] = FUSE;
    if (b && !s) r[47:16] = {img[25], img[24], img[1], img[0]};
    return r;
  endfunction
  task automatic settle(logic b, logic s);
    @(negedge clk);
    base = b;
    sel = s;
    @(negedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
  initial begin
    foreach (img[i]) img[i] = 8'h00;
    repeat (3) @(negedge clk);
    chk("delay_in_reset", 8'h3C, dly_ms);
    chk("hz_in_reset", 8'hFA, hz1);
    resetn = 1;
    repeat (3) @(negedge clk);
    rd_all();
    rd(8'h90, 8'h00, 0);
    for (int i = 0; i < 26; i++) wr(i, (8'h11 * i[7:0]) ^ 8'hA5);
    bus(8'h90, 8'hFF);
    rd_all();
    for (int k = 0; k < 4; k++) begin
      settle(k[1], k[0]);
      chk("config_send_record", exp_rec(k[1], k[0]), rec);
      chk("status_identity", FUSE, sid);
    end
    settle(0, 1);
    chk("status_data", {8{16'hC33C}}, sdata);
    settle(1, 0);
    capture = 1;
    @(negedge clk);
    capture = 0;
    e = exp_rec(1, 0);
    settle(0, 1);
    chk("status_data", e[127:0], sdata);
    settle(0, 0);
    e = exp_rec(0, 0);
    chk("status_data", e[127:0], sdata);
    for (int k = 0; k < 4; k++) begin
      b0 = stab[k];
      b1 = {3'b000, k[1:0], k[1:0] + 2'd1, k[0]};
      wr(18, b0);
      wr(19, b1);
      @(negedge clk);
      chk("delay_ms", dtab[b0[3:2]], dly_ms);
      chk("sensor_flags", {b0[4] & b0[6], b0[6:4]}, {hold, en, pwr, cont});
      chk("rate_selects", {b1[4:0], b0[7]}, {rs1, rs2, rs3});
      chk("rate_hz", {htab[b1[4:3]], htab[b1[2:1]], htab[{b1[0], b0[7]}]},
          {hz1, hz2, hz3});
    end
    @(negedge clk);
    resetn = 0;
    @(negedge clk);
    resetn = 1;
    foreach (img[i]) img[i] = 8'h00;
    repeat (3) @(negedge clk);
    rd_all();
    summarize();
  end
endmodule
bind ocrb_bank ocrb_bank_asserts i_chk (.clk, .resetn, .sfr_addr, .sfr_rd, .sfr_rdata,
  .sfr_hit, .station_is_base, .identity_source_select, .inbound_record, .config_send_record,
  .status_data, .status_identity, .sensor_switch_delay_ms, .continuous_sampling_enable,
  .conversion_enable_hold, .sensor_front_power_enable, .sensor_ctrl_enable,
  .sensor3_rate_select, .sensor1_rate_select, .sensor1_rate_hz);
